// ---- hw/gsd_pattern.sv ----
// Indicator pattern decoder: mode and shared step give lamp colours.
// Assumes step counts 50 ms ticks from 0 to 39 and wraps.
`timescale 1ns/1ps
`default_nettype none
module gsd_pattern (
  input  wire logic              [5:0] step_i,
  input  wire gsd_pkg::gsd_mode_t      mode_i,
  output logic                         grn_o,
  output logic                         red_o
);
  logic on4;
  logic [2:0] slot;
  assign on4  = ~step_i[2];
  assign slot = step_i[5:3];
  always_comb begin
    grn_o = 1'b0;
    red_o = 1'b0;
    unique case (mode_i)
      gsd_pkg::M_OFF:   ;
      gsd_pkg::M_GRN:   grn_o = 1'b1;
      gsd_pkg::M_RED:   red_o = 1'b1;
      gsd_pkg::M_BLK_G: grn_o = on4;
      gsd_pkg::M_BLK_R: red_o = on4;
      gsd_pkg::M_FLICK: begin
        grn_o = step_i[0];
        red_o = ~step_i[0];
      end
      gsd_pkg::M_FL1_G: grn_o = on4 && (slot < 3'h1);
      gsd_pkg::M_FL1_R: red_o = on4 && (slot < 3'h1);
      gsd_pkg::M_FL2_R: red_o = on4 && (slot < 3'h2);
      gsd_pkg::M_FL3_R: red_o = on4 && (slot < 3'h3);
      gsd_pkg::M_FL4_R: red_o = on4 && (slot < 3'h4);
      default:          ;
    endcase
  end
endmodule : gsd_pattern
`default_nettype wire

// ---- hw/gsd_pkg.sv ----
// Types shared by the switch decode and indicator block.
// Assumes the constants of gsd_regs.svh.
package gsd_pkg;
  typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} gsd_par_t;
  typedef enum logic [3:0] {
    M_OFF = 4'h0, M_GRN = 4'h1, M_RED = 4'h2, M_BLK_G = 4'h3, M_BLK_R = 4'h4,
    M_FLICK = 4'h5, M_FL1_G = 4'h6, M_FL1_R = 4'h7, M_FL2_R = 4'h8, M_FL3_R = 4'h9,
    M_FL4_R = 4'ha
  } gsd_mode_t;
  typedef enum logic [1:0] {ST_SETTLE = 2'b01, ST_RUN = 2'b10} gsd_state_t;
  typedef struct packed {
    logic [6:0]  node_addr;
    logic [15:0] bit_cycles;
    gsd_par_t    parity;
    logic        stop2;
    logic        rs232;
    logic        bcast_only;
  } gsd_ser_t;
  typedef struct packed {
    logic bus_err_r;
    logic ready_g;
    logic ready_r;
    logic proc_g;
    logic cfg_r;
    logic net_g;
    logic net_r;
    logic dev_g;
    logic dev_r;
  } gsd_led_t;
endpackage : gsd_pkg

// ---- hw/gsd_regs.svh ----
// Offsets, field positions, reset values and timing counts of the
// switch decode and indicator block. Assumes a 50 MHz core clock.
`ifndef GSD_REGS_SVH
`define GSD_REGS_SVH
`define GSD_CLK_HZ        50000000
`define GSD_TICK_MS       50
`define GSD_SETTLE_MS     1
`define GSD_STEPS         6'h28
`define GSD_FALLBACK_BPS  19200
`define GSD_BPS_1         1200
`define GSD_BPS_2         2400
`define GSD_BPS_3         4800
`define GSD_BPS_4         9600
`define GSD_BPS_5         19200
`define GSD_BPS_6         38400
`define GSD_BPS_7         57600
`define GSD_OFF_STATUS    4'h0
`define GSD_OFF_CTRL      4'h4
`define GSD_OFF_ERR       4'h8
`define GSD_STAT_ADDR_LSB 0
`define GSD_STAT_BAUD_LSB 8
`define GSD_STAT_PAR_LSB  12
`define GSD_STAT_IF_BIT   16
`define GSD_STAT_OK_BIT   17
`define GSD_STAT_DONE_BIT 18
`define GSD_CTRL_RDY_BIT  0
`define GSD_CTRL_TMO_BIT  1
`define GSD_CTRL_CAN_LSB  4
`define GSD_CTRL_DEV_LSB  8
`define GSD_CTRL_RST      12'h000
`define GSD_ERR_BIT       0
`endif

// ---- hw/gsd_sync.sv ----
// Two flip-flop synchroniser for a bus of slow pin levels.
// Assumes each bit changes rarely; bits are not coherent.
`timescale 1ns/1ps
`default_nettype none
module gsd_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : gsd_sync
`default_nettype wire

// ---- hw/gsd_top.sv ----
// Serial slave switch decode and front-panel indicators, AXI4-Lite slave.
// Assumes switch pins are asynchronous; event inputs share core_clk_i.
// Overview of operation
// - Node address is binary seven-switch value
// - Switches captured once after reset only
// - Three-bit baud code selects 1.2-57.6 kbit/s
// - Two-bit parity code selects parity, stop bits
// - Interface switch off RS-485, on RS-232
// - Invalid switches: red lamp, 19200, broadcast only
// - Bus error lamp red once error detected
// - Processing lamp flashes green during requests
// - Network lamp shows network operating states
// - Network lamp shows network fault codes
// - Lamps 1-4 serial, 5-6 network, device
`timescale 1ns/1ps
`default_nettype none
`include "gsd_regs.svh"
module gsd_top #(
  parameter int TICK_CYC   = `GSD_TICK_MS * (`GSD_CLK_HZ / 1000),
  parameter int SETTLE_CYC = `GSD_SETTLE_MS * (`GSD_CLK_HZ / 1000)
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [6:0]        addr_sw_i,
  input  wire logic [7:0]        cfg_sw_i,
  input  wire logic              bus_err_i,
  input  wire logic              query_busy_i,
  output gsd_pkg::gsd_ser_t      ser_cfg_o,
  output logic                   cfg_done_o,
  output gsd_pkg::gsd_led_t      led_o,
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  localparam int CLK = `GSD_CLK_HZ;

  logic [6:0]          addr_s;
  logic [7:0]          cfg_s;
  gsd_pkg::gsd_state_t state_r;
  logic [31:0]         settle_r;
  logic [6:0]          addr_r;
  logic [2:0]          baud_r;
  logic [1:0]          par_r;
  logic                if_r;
  logic                ok_nxt;
  logic [15:0]         cyc_nxt;
  logic [11:0]         ctrl_r;
  logic                err_r;
  logic [31:0]         tick_r;
  logic [5:0]          step_r;
  gsd_pkg::gsd_mode_t  mode_sel [3];
  logic [2:0]          pat_g;
  logic [2:0]          pat_r;
  logic                aw_have_r;
  logic                w_have_r;
  logic [3:0]          awaddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                aw_fire;
  logic                w_fire;
  logic                ar_fire;
  logic                wr_go;
  logic [31:0]         rd_mux;
  logic                rd_hit;

  gsd_sync #(.W(15)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .d_i        ({addr_sw_i, cfg_sw_i}),
    .q_o        ({addr_s, cfg_s})
  );

  // Startup sequencer: wait for the pins to settle, then run forever
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r  <= gsd_pkg::ST_SETTLE;
      settle_r <= 32'h0000_0000;
    end else begin
      unique case (state_r)
        gsd_pkg::ST_SETTLE: begin
          if (settle_r == 32'(SETTLE_CYC - 1)) begin
            state_r <= gsd_pkg::ST_RUN;
          end else begin
            settle_r <= settle_r + 32'h0000_0001;
          end
        end
        gsd_pkg::ST_RUN: state_r <= gsd_pkg::ST_RUN;
      endcase
    end
  end

  // Single capture at the end of settling; later moves ignored
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_r <= 7'h00;
      baud_r <= 3'h0;
      par_r  <= 2'h0;
      if_r   <= 1'b0;
    end else if (state_r == gsd_pkg::ST_SETTLE && settle_r == 32'(SETTLE_CYC - 1)) begin
      addr_r <= addr_s;
      baud_r <= {cfg_s[7], cfg_s[0], cfg_s[1]};
      par_r  <= {cfg_s[2], cfg_s[3]};
      if_r   <= cfg_s[4];
    end
  end

  assign ok_nxt = (baud_r != 3'h0) && (par_r != 2'h0);

  always_comb begin
    unique case (baud_r)
      3'h1:    cyc_nxt = 16'(CLK / `GSD_BPS_1);
      3'h2:    cyc_nxt = 16'(CLK / `GSD_BPS_2);
      3'h3:    cyc_nxt = 16'(CLK / `GSD_BPS_3);
      3'h4:    cyc_nxt = 16'(CLK / `GSD_BPS_4);
      3'h5:    cyc_nxt = 16'(CLK / `GSD_BPS_5);
      3'h6:    cyc_nxt = 16'(CLK / `GSD_BPS_6);
      3'h7:    cyc_nxt = 16'(CLK / `GSD_BPS_7);
      default: cyc_nxt = 16'(CLK / `GSD_FALLBACK_BPS);
    endcase
    if (!ok_nxt) begin
      cyc_nxt = 16'(CLK / `GSD_FALLBACK_BPS);
    end
  end

  // Serial port settings handed to the serial engine
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ser_cfg_o  <= '0;
      cfg_done_o <= 1'b0;
    end else begin
      cfg_done_o           <= (state_r == gsd_pkg::ST_RUN);
      ser_cfg_o.node_addr  <= addr_r;
      ser_cfg_o.bit_cycles <= cyc_nxt;
      ser_cfg_o.rs232      <= if_r;
      ser_cfg_o.bcast_only <= !ok_nxt;
      ser_cfg_o.stop2      <= !ok_nxt || (par_r == 2'h1);
      unique case ({ok_nxt, par_r})
        3'h6:    ser_cfg_o.parity <= gsd_pkg::PAR_EVEN;
        3'h7:    ser_cfg_o.parity <= gsd_pkg::PAR_ODD;
        default: ser_cfg_o.parity <= gsd_pkg::PAR_NONE;
      endcase
    end
  end

  // Sticky bus error; a new error beats a software clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_r <= 1'b0;
    end else if (bus_err_i) begin
      err_r <= 1'b1;
    end else if (wr_go && awaddr_r == `GSD_OFF_ERR && wstrb_r[0] && wdata_r[`GSD_ERR_BIT]) begin
      err_r <= 1'b0;
    end
  end

  // Software-set link and device state
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `GSD_CTRL_RST;
    end else if (wr_go && awaddr_r == `GSD_OFF_CTRL) begin
      if (wstrb_r[0]) begin
        ctrl_r[7:0] <= wdata_r[7:0];
      end
      if (wstrb_r[1]) begin
        ctrl_r[11:8] <= wdata_r[11:8];
      end
    end
  end

  // Shared pattern timebase: 50 ms ticks, 40-step frame
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_r <= 32'h0000_0000;
      step_r <= 6'h00;
    end else if (tick_r == 32'(TICK_CYC - 1)) begin
      tick_r <= 32'h0000_0000;
      step_r <= (step_r == `GSD_STEPS - 6'h01) ? 6'h00 : step_r + 6'h01;
    end else begin
      tick_r <= tick_r + 32'h0000_0001;
    end
  end

  // Pattern selection for lamps 3, 5 and 6
  always_comb begin
    mode_sel[0] = query_busy_i ? gsd_pkg::M_BLK_G : gsd_pkg::M_OFF;
    unique case (ctrl_r[`GSD_CTRL_CAN_LSB +: 4])
      4'h1:    mode_sel[1] = gsd_pkg::M_FLICK;
      4'h2:    mode_sel[1] = gsd_pkg::M_BLK_G;
      4'h3:    mode_sel[1] = gsd_pkg::M_FL1_G;
      4'h4:    mode_sel[1] = gsd_pkg::M_GRN;
      4'h5:    mode_sel[1] = gsd_pkg::M_BLK_R;
      4'h6:    mode_sel[1] = gsd_pkg::M_FL1_R;
      4'h7:    mode_sel[1] = gsd_pkg::M_FL2_R;
      4'h8:    mode_sel[1] = gsd_pkg::M_FL3_R;
      4'h9:    mode_sel[1] = gsd_pkg::M_FL4_R;
      4'ha:    mode_sel[1] = gsd_pkg::M_RED;
      default: mode_sel[1] = gsd_pkg::M_OFF;
    endcase
    unique case (ctrl_r[`GSD_CTRL_DEV_LSB +: 4])
      4'h1:    mode_sel[2] = gsd_pkg::M_FL1_R;
      4'h2:    mode_sel[2] = gsd_pkg::M_FL2_R;
      4'h3:    mode_sel[2] = gsd_pkg::M_FL3_R;
      4'h4:    mode_sel[2] = gsd_pkg::M_RED;
      default: mode_sel[2] = gsd_pkg::M_GRN;
    endcase
    if (state_r == gsd_pkg::ST_SETTLE) begin
      mode_sel[2] = gsd_pkg::M_BLK_G;
    end else if (!ok_nxt && ctrl_r[`GSD_CTRL_DEV_LSB +: 4] != 4'h4) begin
      mode_sel[2] = gsd_pkg::M_FL4_R;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_pat
    gsd_pattern u_pat (
      .step_i (step_r),
      .mode_i (mode_sel[i]),
      .grn_o  (pat_g[i]),
      .red_o  (pat_r[i])
    );
  end

  // Lamp drivers, lamps 1-4 serial side, 5-6 network and device
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_o <= '0;
    end else begin
      led_o.bus_err_r <= err_r;
      led_o.ready_r   <= ctrl_r[`GSD_CTRL_TMO_BIT];
      led_o.ready_g   <= ctrl_r[`GSD_CTRL_RDY_BIT] && !ctrl_r[`GSD_CTRL_TMO_BIT];
      led_o.proc_g    <= pat_g[0];
      led_o.cfg_r     <= (state_r == gsd_pkg::ST_RUN) && !ok_nxt;
      led_o.net_g     <= pat_g[1];
      led_o.net_r     <= pat_r[1];
      led_o.dev_g     <= pat_g[2];
      led_o.dev_r     <= pat_r[2];
    end
  end

  // AXI4-Lite write side
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire  = s_axi_wvalid && s_axi_wready;
  assign wr_go   = aw_have_r && w_have_r && !s_axi_bvalid;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_have_r     <= 1'b0;
      awaddr_r      <= 4'h0;
      s_axi_awready <= 1'b0;
    end else if (aw_fire) begin
      aw_have_r     <= 1'b1;
      awaddr_r      <= {s_axi_awaddr[3:2], 2'b00};
      s_axi_awready <= 1'b0;
    end else begin
      if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      s_axi_awready <= !aw_have_r && !s_axi_bvalid;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_have_r     <= 1'b0;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (w_fire) begin
      w_have_r     <= 1'b1;
      wdata_r      <= s_axi_wdata;
      wstrb_r      <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      if (wr_go) begin
        w_have_r <= 1'b0;
      end
      s_axi_wready <= !w_have_r && !s_axi_bvalid;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r == `GSD_OFF_CTRL || awaddr_r == `GSD_OFF_ERR) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read side
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[3:2], 2'b00})
      `GSD_OFF_STATUS: begin
        rd_mux[`GSD_STAT_ADDR_LSB +: 7] = addr_r;
        rd_mux[`GSD_STAT_BAUD_LSB +: 3] = baud_r;
        rd_mux[`GSD_STAT_PAR_LSB +: 2]  = par_r;
        rd_mux[`GSD_STAT_IF_BIT]        = if_r;
        rd_mux[`GSD_STAT_OK_BIT]        = ok_nxt;
        rd_mux[`GSD_STAT_DONE_BIT]      = (state_r == gsd_pkg::ST_RUN);
      end
      `GSD_OFF_CTRL: rd_mux[11:0] = ctrl_r;
      `GSD_OFF_ERR:  rd_mux[`GSD_ERR_BIT] = err_r;
      default:       rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule : gsd_top
`default_nettype wire

// ---- tb/gsd_master_model.sv ----
// Serial master side model: marks request handling and bus faults.
// Assumes the bench calls its tasks from the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module gsd_master_model (
  input  wire logic core_clk_i,
  output logic      query_busy_o,
  output logic      bus_err_o
);
  initial begin
    query_busy_o = 1'b0;
    bus_err_o    = 1'b0;
  end
  // Request in progress as a level
  task automatic set_busy(input logic v);
    @(posedge core_clk_i);
    query_busy_o <= v;
  endtask : set_busy
  // One-cycle bus fault pulse
  task automatic fault();
    @(posedge core_clk_i);
    bus_err_o <= 1'b1;
    @(posedge core_clk_i);
    bus_err_o <= 1'b0;
  endtask : fault
endmodule : gsd_master_model
`default_nettype wire

// ---- tb/gsd_top_monitor.sv ----
// Concurrent checks on the switch decode and indicator block.
// Assumes bind onto gsd_top, single core clock domain.
`timescale 1ns/1ps
`default_nettype none
module gsd_top_monitor (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              bus_err_i,
  input  wire logic              query_busy_i,
  input  wire gsd_pkg::gsd_ser_t ser_cfg_o,
  input  wire logic              cfg_done_o,
  input  wire gsd_pkg::gsd_led_t led_o,
  input  wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [31:0]       s_axi_rdata
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_cfg_frozen;
    cfg_done_o && $past(cfg_done_o) |-> $stable(ser_cfg_o);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("config changed after capture");
  property p_fallback_rate;
    cfg_done_o && ser_cfg_o.bcast_only |-> ser_cfg_o.bit_cycles == 16'h0a2c;
  endproperty
  a_fallback_rate: assert property (p_fallback_rate) else $error("fallback rate wrong");
  property p_cfg_lamp;
    cfg_done_o && $past(cfg_done_o, 2) |-> led_o.cfg_r == ser_cfg_o.bcast_only;
  endproperty
  a_cfg_lamp: assert property (p_cfg_lamp) else $error("settings lamp mismatch");
  property p_stop_parity;
    cfg_done_o |-> (ser_cfg_o.parity == gsd_pkg::PAR_NONE) == ser_cfg_o.stop2;
  endproperty
  a_stop_parity: assert property (p_stop_parity) else $error("stop bits and parity disagree");
  property p_err_lamp;
    bus_err_i |-> ##[1:2] led_o.bus_err_r;
  endproperty
  a_err_lamp: assert property (p_err_lamp) else $error("bus error lamp not lit");
  property p_idle_lamp;
    !query_busy_i [*3] |-> !led_o.proc_g;
  endproperty
  a_idle_lamp: assert property (p_idle_lamp) else $error("processing lamp lit while idle");
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read response dropped");
endmodule : gsd_top_monitor
bind gsd_top gsd_top_monitor u_mon (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus_err_i(bus_err_i), .query_busy_i(query_busy_i),
  .ser_cfg_o(ser_cfg_o), .cfg_done_o(cfg_done_o), .led_o(led_o), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata)
);
`default_nettype wire

// ---- tb/test_gateway_switch_decode_status_leds.sv ----
// Self-checking bench for the switch decode and indicator block.
// Assumes short tick and settle counts and the master model.
`timescale 1ns/1ps
`default_nettype none
module test_gateway_switch_decode_status_leds;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [6:0] asw = 7'h00;
  logic [7:0] csw = 8'h00;
  logic busy, berr;
  gsd_pkg::gsd_ser_t ser;
  gsd_pkg::gsd_led_t led;
  logic done, awv = 1'b0, wv = 1'b0, bv, br = 1'b0, arv = 1'b0, rv, rr = 1'b0, awr, wr, arr;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0000_0000, rd;
  logic [1:0] bresp, rresp;
  int mismatches = 0, compares = 0, cyc = 0;
  initial forever #10 clk = ~clk;
  gsd_master_model u_mst (.core_clk_i(clk), .query_busy_o(busy), .bus_err_o(berr));
  gsd_top #(.TICK_CYC(4), .SETTLE_CYC(8)) uut (
    .core_clk_i(clk), .rst_n_i(rst_n), .addr_sw_i(asw), .cfg_sw_i(csw), .bus_err_i(berr),
    .query_busy_i(busy), .ser_cfg_o(ser), .cfg_done_o(done), .led_o(led),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!(bv && !awv && !wv));
    br <= 1'b1;
    do @(posedge clk); while (!bv);
    br <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    ara <= a; arv <= 1'b1;
    do @(posedge clk); while (!(arv && arr));
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rr <= 1'b1;
    do @(posedge clk); while (!rv);
    rr <= 1'b0;
    chk("rdata", ed, rd);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : axi_rd
  // Switch bank from baud, parity and interface codes
  function automatic logic [7:0] mk(input logic [2:0] b, input logic [1:0] p, input logic i);
    return {b[2], 2'b00, i, p[0], p[1], b[0], b[1]};
  endfunction : mk
  // Lamp-on cycles over one whole 40-step frame of 4-cycle ticks
  task automatic frame(output int ng, output int nr, output int dg, output int dr);
    ng = 0;
    nr = 0;
    dg = 0;
    dr = 0;
    repeat (2) @(posedge clk);
    repeat (160) begin
      @(posedge clk);
      ng += led.net_g;
      nr += led.net_r;
      dg += led.dev_g;
      dr += led.dev_r;
    end
  endtask : frame
  task automatic boot(input logic [6:0] a, input logic [7:0] c);
    @(posedge clk);
    asw <= a; csw <= c; rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 30 && !done; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("cfg_done", 32'h1, {31'h0, done});
  endtask : boot
  task automatic t_valid();
    int bps[7] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600};
    logic [1:0] pe[3] = '{2'h0, 2'h1, 2'h2};
    for (int b = 1; b < 8; b++) begin
      boot(7'h7f - 7'(b), mk(3'(b), 2'h1, 1'b0));
      chk("node_addr", 32'h7f - b, {25'h0, ser.node_addr});
      chk("bit_cycles", 50000000 / bps[b-1], {16'h0, ser.bit_cycles});
      chk("bcast_only", 32'h0, {31'h0, ser.bcast_only});
      chk("cfg_r", 32'h0, {31'h0, led.cfg_r});
    end
    for (int p = 1; p < 4; p++) begin
      boot(7'h2a, mk(3'h5, 2'(p), 1'b1));
      chk("parity", {30'h0, pe[p-1]}, {30'h0, ser.parity});
      chk("stop2", p == 1, {31'h0, ser.stop2});
      chk("rs232", 32'h1, {31'h0, ser.rs232});
    end
    $display("valid switch test done");
  endtask : t_valid
  task automatic t_invalid();
    int ng, nr, dg, dr;
    boot(7'h05, mk(3'h0, 2'h2, 1'b1));
    chk("bit_cycles", 32'h0a2c, {16'h0, ser.bit_cycles});
    chk("bcast_only", 32'h1, {31'h0, ser.bcast_only});
    chk("cfg_r", 32'h1, {31'h0, led.cfg_r});
    chk("parity", 32'h0, {30'h0, ser.parity});
    chk("stop2", 32'h1, {31'h0, ser.stop2});
    frame(ng, nr, dg, dr);
    chk("dev_quad", 32'h0000_0040, {dg[15:0], dr[15:0]});
    chk("net_off", 32'h0000_0000, {ng[15:0], nr[15:0]});
    axi_rd(4'h0, 32'h0005_2005, 2'h0);
    boot(7'h05, mk(3'h3, 2'h0, 1'b0));
    chk("bcast_only", 32'h1, {31'h0, ser.bcast_only});
    chk("rs232", 32'h0, {31'h0, ser.rs232});
    $display("invalid switch test done");
  endtask : t_invalid
  task automatic t_frozen();
    boot(7'h2a, mk(3'h4, 2'h2, 1'b0));
    @(posedge clk);
    asw <= 7'h11; csw <= mk(3'h7, 2'h3, 1'b1);
    repeat (30) @(posedge clk);
    chk("node_addr", 32'h2a, {25'h0, ser.node_addr});
    chk("bit_cycles", 32'd5208, {16'h0, ser.bit_cycles});
    axi_rd(4'h0, 32'h0006_242a, 2'h0);
    $display("capture once test done");
  endtask : t_frozen
  task automatic t_lamps();
    axi_wr(4'h4, 32'h0000_04a1, 2'h0);
    repeat (4) @(posedge clk);
    chk("ready_g", 32'h1, {31'h0, led.ready_g});
    chk("net_r", 32'h1, {31'h0, led.net_r & ~led.net_g});
    chk("dev_r", 32'h1, {31'h0, led.dev_r & ~led.dev_g});
    axi_wr(4'h4, 32'h0000_0043, 2'h0);
    repeat (4) @(posedge clk);
    chk("ready_r", 32'h1, {31'h0, led.ready_r & ~led.ready_g});
    chk("net_g", 32'h1, {31'h0, led.net_g & ~led.net_r});
    chk("dev_g", 32'h1, {31'h0, led.dev_g & ~led.dev_r});
    axi_rd(4'h4, 32'h0000_0043, 2'h0);
    axi_wr(4'hc, 32'h0000_0001, 2'h2);
    axi_rd(4'hc, 32'h0000_0000, 2'h2);
    $display("lamp register test done");
  endtask : t_lamps
  task automatic t_patterns();
    int ng, nr, dg, dr;
    axi_wr(4'h4, 32'h0000_0271, 2'h0);
    frame(ng, nr, dg, dr);
    chk("net_dbl", 32'h0000_0020, {ng[15:0], nr[15:0]});
    chk("dev_dbl", 32'h0000_0020, {dg[15:0], dr[15:0]});
    axi_wr(4'h4, 32'h0000_0311, 2'h0);
    frame(ng, nr, dg, dr);
    chk("net_flick", 32'h0050_0050, {ng[15:0], nr[15:0]});
    chk("dev_tri", 32'h0000_0030, {dg[15:0], dr[15:0]});
    axi_wr(4'h4, 32'h0000_0031, 2'h0);
    frame(ng, nr, dg, dr);
    chk("net_fl1_g", 32'h0010_0000, {ng[15:0], nr[15:0]});
    chk("dev_run", 32'h00a0_0000, {dg[15:0], dr[15:0]});
    $display("pattern test done");
  endtask : t_patterns
  task automatic t_events();
    int seen;
    chk("bus_err_r", 32'h0, {31'h0, led.bus_err_r});
    u_mst.fault();
    repeat (3) @(posedge clk);
    chk("bus_err_r", 32'h1, {31'h0, led.bus_err_r});
    axi_rd(4'h8, 32'h0000_0001, 2'h0);
    axi_wr(4'h8, 32'h0000_0001, 2'h0);
    repeat (3) @(posedge clk);
    chk("bus_err_r", 32'h0, {31'h0, led.bus_err_r});
    u_mst.set_busy(1'b1);
    seen = 0;
    repeat (40) begin
      @(posedge clk);
      if (led.proc_g === 1'b1) seen++;
    end
    chk("proc_flash", 32'h1, {31'h0, seen > 0 && seen < 40});
    u_mst.set_busy(1'b0);
    repeat (4) @(posedge clk);
    chk("proc_g", 32'h0, {31'h0, led.proc_g});
    $display("event lamp test done");
  endtask : t_events
  initial begin
    repeat (6) @(posedge clk);
    t_valid();
    t_invalid();
    t_frozen();
    t_lamps();
    t_patterns();
    t_events();
    end_sim();
  end
endmodule : test_gateway_switch_decode_status_leds
`default_nettype wire
